// file: logic/pmc_pkg.sv
// constants, offsets and mode encoding for the power mode controller
package pmc_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_PC0        = 8'h00;
    localparam logic [7:0] OFF_PC1        = 8'h04;
    localparam logic [7:0] OFF_REGCTL     = 8'h08;
    localparam logic [7:0] OFF_CLKCTL     = 8'h0c;
    localparam logic [7:0] OFF_PERIPH     = 8'h10;
    localparam logic [7:0] OFF_MODE       = 8'h14;
    localparam logic [7:0] OFF_INT_STATUS = 8'h18;
    localparam logic [7:0] OFF_INT_MASK   = 8'h1c;
    // field positions
    localparam int PC0_IDLE_BIT      = 0;
    localparam int PC0_STOP_BIT      = 1;
    localparam int PC1_SUSPEND_BIT   = 0;
    localparam int PC1_SNOOZE_BIT    = 1;
    localparam int REG_STOP_SEL_BIT  = 0;
    localparam int REG_FIVE_V_BIT    = 1;
    localparam int CLK_OSC_A_BIT     = 0;
    localparam int CLK_OSC_B_BIT     = 1;
    localparam int CLK_SLOW_TMR_BIT  = 2;
    localparam int INT_IDLE_WAKE_BIT = 0;
    localparam int INT_LP_WAKE_BIT   = 1;
    localparam int INT_REFUSED_BIT   = 2;
    localparam int INT_W             = 3;
    // reset values
    localparam logic [1:0]  REGCTL_RESET      = 2'h0;
    localparam logic [2:0]  CLKCTL_RESET      = 3'h1;
    localparam logic        PERIPH_RESET_BIT  = 1'b1;
    localparam logic [INT_W-1:0] INT_RESET    = 3'h0;
    // bus responses
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // synchroniser lanes for asynchronous wake and reset sources
    localparam int WS_TIMER4    = 0;
    localparam int WS_SPI       = 1;
    localparam int WS_TWI       = 2;
    localparam int WS_PORT      = 3;
    localparam int WS_CMP       = 4;
    localparam int WS_PIN_RST   = 5;
    localparam int WS_POR       = 6;
    localparam int WS_OTHER_RST = 7;
    localparam int SYNC_W       = 8;
    // power modes
    typedef enum logic [2:0]
    {
        MODE_NORMAL   = 3'b000,
        MODE_IDLE     = 3'b001,
        MODE_SUSPEND  = 3'b010,
        MODE_SNOOZE   = 3'b011,
        MODE_STOP     = 3'b100,
        MODE_SHUTDOWN = 3'b101
    } mode_t;
endpackage : pmc_pkg

// file: logic/level_sync.sv
// two-flop synchroniser for a group of asynchronous levels
module level_sync
    import pmc_pkg::*;
#(
    parameter int WIDTH = SYNC_W
)
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one;

    // first stage feeds only the second stage
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stage_one <= '0;
            sync_out  <= '0;
        end
        else if (ce)
        begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end
endmodule : level_sync

// file: logic/power_mode_controller.sv
// power mode sequencer with axi4-lite control registers
//
// Functional notes
// [R1] normal mode clocks core and every peripheral; the code clocks only the peripherals set in periph_enable
// [R2] idle bit write halts the core
// [R3] idle keeps peripherals clocked and working
// [R4] wake resumes program; sources depend on mode
// [R5] suspend needs oscillator a selected first
// [R6] snooze needs oscillator a selected first
// [R7] suspend/snooze halt clocks and fast oscillators
// [R8] suspend keeps regulators at normal bias
// [R9] snooze puts regulators in low bias
// [R10] slow timers may run in suspend/snooze
// [R11] listed peripheral events wake suspend/snooze
// [R12] stop select clear plus stop enters stop
// [R13] any reset source leaves stop
// [R14] stop select set plus stop enters shutdown
// [R15] only pin or power-on reset leaves shutdown
// [R16] stop/shutdown power nets off, pins held
// [R17] enabled five volt regulator stays on
// [R18] unused peripheral clocks gated off
// [R19] leaving stop/shutdown restarts from reset state
module power_mode_controller
    import pmc_pkg::*;
#(
    parameter int NUM_PERIPH = 8
)
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  ce,
    // axi4-lite slave
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // wake and reset sources
    input  wire logic                  any_interrupt,
    input  wire logic                  timer4_event,
    input  wire logic                  spi_activity,
    input  wire logic                  two_wire_slave_activity,
    input  wire logic                  port_match_event,
    input  wire logic                  comparator0_out,
    input  wire logic                  external_reset_pin_n,
    input  wire logic                  power_on_reset,
    input  wire logic                  other_reset,
    // power and clock controls
    output logic                       core_clk_en,
    output logic [NUM_PERIPH-1:0]      periph_clk_en,
    output logic                       fast_internal_osc_a_en,
    output logic                       fast_internal_osc_b_en,
    output logic                       slow_timer_clk_en,
    output logic                       regulator_low_bias,
    output logic                       ldo_on,
    output logic                       power_nets_on,
    output logic                       pin_hold,
    output logic                       five_volt_reg_en,
    output logic                       core_restart,
    output logic [2:0]                 power_mode,
    output logic                       irq
);
    mode_t                 mode;
    mode_t                 next_mode;
    logic [SYNC_W-1:0]     src_sync;
    logic                  cmp_prev;
    logic                  cmp_fall;
    logic                  wake_lp;
    logic                  any_reset;
    logic                  pin_or_por;
    logic                  restart_next;
    logic                  aw_got;
    logic                  w_got;
    logic [7:0]            wr_addr;
    logic [31:0]           wr_data;
    logic                  wr_lane0;
    logic                  wr_go;
    logic [1:0]            regulator_control;
    logic [2:0]            clock_control;
    logic [NUM_PERIPH-1:0] periph_enable;
    logic [INT_W-1:0]      int_status;
    logic [INT_W-1:0]      int_mask;
    logic [INT_W-1:0]      int_set;
    logic                  pc0_wr;
    logic                  pc1_wr;
    logic                  lp_request;
    logic                  lp_refused;

    // true when an address lands in the word at the given offset
    function automatic logic hits(input logic [7:0] addr, input logic [7:0] off);
        hits = (addr[7:2] == off[7:2]);
    endfunction : hits

    function automatic logic is_low_power(input mode_t m);
        is_low_power = (m == MODE_SUSPEND) || (m == MODE_SNOOZE);
    endfunction : is_low_power

    // asynchronous sources pass two flops
    level_sync #(.WIDTH(SYNC_W)) u_sync
    (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .ce       (ce),
        .async_in ({other_reset, power_on_reset, ~external_reset_pin_n, comparator0_out,
                    port_match_event, two_wire_slave_activity, spi_activity, timer4_event}),
        .sync_out (src_sync)
    );

    // comparator edge seen after synchronisation
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cmp_prev <= 1'b0;
        else if (ce)
            cmp_prev <= src_sync[WS_CMP];
    end

    // [R11] low-power wake sources
    assign cmp_fall   = cmp_prev && !src_sync[WS_CMP];
    assign wake_lp    = src_sync[WS_TIMER4] | src_sync[WS_SPI] | src_sync[WS_TWI] | src_sync[WS_PORT] | cmp_fall;
    assign any_reset  = src_sync[WS_PIN_RST] | src_sync[WS_POR] | src_sync[WS_OTHER_RST];
    assign pin_or_por = src_sync[WS_PIN_RST] | src_sync[WS_POR];

    // write address and data accepted in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            wr_addr       <= 8'h00;
            wr_data       <= 32'h0000_0000;
            wr_lane0      <= 1'b0;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got        <= 1'b1;
                s_axi_awready <= 1'b0;
                wr_addr       <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got        <= 1'b1;
                s_axi_wready <= 1'b0;
                wr_data      <= s_axi_wdata;
                wr_lane0     <= s_axi_wstrb[0];
            end
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_addr[7:2] <= OFF_INT_MASK[7:2]) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                aw_got        <= 1'b0;
                w_got         <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    assign wr_go  = aw_got && w_got && !s_axi_bvalid;
    assign pc0_wr = wr_go && wr_lane0 && hits(wr_addr, OFF_PC0);
    assign pc1_wr = wr_go && wr_lane0 && hits(wr_addr, OFF_PC1);

    // [R5] suspend or snooze refused unless oscillator a drives the system clock
    assign lp_request = pc1_wr && (wr_data[PC1_SUSPEND_BIT] || wr_data[PC1_SNOOZE_BIT]) && (mode == MODE_NORMAL);
    assign lp_refused = lp_request && !clock_control[CLK_OSC_A_BIT];

    // read channel answers one cycle after the address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= RESP_OKAY;
                s_axi_rdata   <= 32'h0000_0000;
                if (hits(s_axi_araddr, OFF_PC0) || hits(s_axi_araddr, OFF_PC1))
                    s_axi_rdata <= 32'h0000_0000;
                else if (hits(s_axi_araddr, OFF_REGCTL))
                    s_axi_rdata <= {30'h0, regulator_control};
                else if (hits(s_axi_araddr, OFF_CLKCTL))
                    s_axi_rdata <= {29'h0, clock_control};
                else if (hits(s_axi_araddr, OFF_PERIPH))
                    s_axi_rdata <= 32'(periph_enable);
                else if (hits(s_axi_araddr, OFF_MODE))
                    s_axi_rdata <= {29'h0, mode};
                else if (hits(s_axi_araddr, OFF_INT_STATUS))
                    s_axi_rdata <= {29'h0, int_status};
                else if (hits(s_axi_araddr, OFF_INT_MASK))
                    s_axi_rdata <= {29'h0, int_mask};
                else
                    s_axi_rresp <= RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // software control registers, returned to reset values on restart
    always_ff @(posedge aclk)
    begin
        if (!aresetn || core_restart)
        begin
            regulator_control <= REGCTL_RESET;
            clock_control     <= CLKCTL_RESET;
            periph_enable     <= {NUM_PERIPH{PERIPH_RESET_BIT}};
            int_mask          <= INT_RESET;
        end
        else if (ce && wr_go && wr_lane0)
        begin
            if (hits(wr_addr, OFF_REGCTL))
                regulator_control <= wr_data[1:0];
            else if (hits(wr_addr, OFF_CLKCTL))
                clock_control <= wr_data[2:0];
            else if (hits(wr_addr, OFF_PERIPH))
                periph_enable <= wr_data[NUM_PERIPH-1:0];
            else if (hits(wr_addr, OFF_INT_MASK))
                int_mask <= wr_data[INT_W-1:0];
        end
    end

    // mode sequencing
    always_comb
    begin
        next_mode    = mode;
        restart_next = 1'b0;
        case (mode)
            MODE_NORMAL:
            begin
                // [R12] stop select chooses stop or shutdown
                if (pc0_wr && wr_data[PC0_STOP_BIT])
                    next_mode = regulator_control[REG_STOP_SEL_BIT] ? MODE_SHUTDOWN : MODE_STOP;
                // [R2] idle request halts the core
                else if (pc0_wr && wr_data[PC0_IDLE_BIT])
                    next_mode = MODE_IDLE;
                // [R6] snooze and suspend only after oscillator a selected
                else if (lp_request && !lp_refused)
                    next_mode = wr_data[PC1_SNOOZE_BIT] ? MODE_SNOOZE : MODE_SUSPEND;
            end
            // [R4] any interrupt ends idle
            MODE_IDLE:
                if (any_interrupt)
                    next_mode = MODE_NORMAL;
            MODE_SUSPEND, MODE_SNOOZE:
                if (wake_lp)
                    next_mode = MODE_NORMAL;
            // [R13] every reset source ends stop
            MODE_STOP:
                if (any_reset)
                begin
                    next_mode    = MODE_NORMAL;
                    restart_next = 1'b1;
                end
            // [R15] only pin or power-on reset ends shutdown
            MODE_SHUTDOWN:
                if (pin_or_por)
                begin
                    next_mode    = MODE_NORMAL;
                    restart_next = 1'b1;
                end
            default:
                next_mode = MODE_NORMAL;
        endcase
    end

    // [R19] mode register and restart pulse
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode         <= MODE_NORMAL;
            core_restart <= 1'b0;
        end
        else if (ce)
        begin
            mode         <= next_mode;
            core_restart <= restart_next;
        end
    end

    // sticky events, a set in the clearing cycle survives
    assign int_set[INT_IDLE_WAKE_BIT] = (mode == MODE_IDLE) && (next_mode == MODE_NORMAL);
    assign int_set[INT_LP_WAKE_BIT]   = is_low_power(mode) && (next_mode == MODE_NORMAL);
    assign int_set[INT_REFUSED_BIT]   = lp_refused;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || core_restart)
        begin
            int_status <= INT_RESET;
            irq        <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_go && wr_lane0 && hits(wr_addr, OFF_INT_STATUS))
                int_status <= (int_status & ~wr_data[INT_W-1:0]) | int_set;
            else
                int_status <= int_status | int_set;
            irq <= |(int_status & int_mask);
        end
    end

    // clock, oscillator and supply controls follow the next mode, except the five volt regulator
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            core_clk_en            <= 1'b1;
            periph_clk_en          <= {NUM_PERIPH{PERIPH_RESET_BIT}};
            fast_internal_osc_a_en <= 1'b1;
            fast_internal_osc_b_en <= 1'b0;
            slow_timer_clk_en      <= 1'b0;
            regulator_low_bias     <= 1'b0;
            ldo_on                 <= 1'b1;
            power_nets_on          <= 1'b1;
            pin_hold               <= 1'b0;
            five_volt_reg_en       <= 1'b0;
            power_mode             <= MODE_NORMAL;
        end
        else if (ce)
        begin
            // [R1] core runs only in normal
            core_clk_en            <= (next_mode == MODE_NORMAL);
            // [R3] peripherals clocked in normal and idle, [R18] unused ones gated
            periph_clk_en          <= (next_mode == MODE_NORMAL || next_mode == MODE_IDLE) ? periph_enable : '0;
            // [R7] fast oscillators stop outside normal and idle
            fast_internal_osc_a_en <= (next_mode == MODE_NORMAL || next_mode == MODE_IDLE);
            fast_internal_osc_b_en <= (next_mode == MODE_NORMAL || next_mode == MODE_IDLE)
                                      && clock_control[CLK_OSC_B_BIT];
            // [R10] timers three and four on the slow oscillator
            slow_timer_clk_en      <= clock_control[CLK_SLOW_TMR_BIT] && !next_mode[2];
            // [R8] suspend normal bias, [R9] snooze low bias
            regulator_low_bias     <= (next_mode == MODE_SNOOZE);
            // [R14] shutdown switches the core regulator off
            ldo_on                 <= (next_mode != MODE_SHUTDOWN);
            // [R16] stop and shutdown drop nets and hold pins
            power_nets_on          <= !next_mode[2];
            pin_hold               <= next_mode[2];
            // [R17] five volt regulator follows software in every mode
            five_volt_reg_en       <= regulator_control[REG_FIVE_V_BIT];
            power_mode             <= next_mode;
        end
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_idle_entry: assert property (ce && pc0_wr && wr_data[PC0_IDLE_BIT] && !wr_data[PC0_STOP_BIT]
        && mode == MODE_NORMAL |=> mode == MODE_IDLE && !core_clk_en) // [R2]
        else $error("idle request did not halt core");
    a_idle_periph: assert property (mode == MODE_IDLE && ce |=> periph_clk_en == $past(periph_enable)
        || mode != MODE_IDLE) // [R3]
        else $error("peripheral clocks lost in idle");
    a_lp_clocks: assert property (ce && is_low_power(next_mode) |=> !core_clk_en && periph_clk_en == '0
        && !fast_internal_osc_a_en && !fast_internal_osc_b_en) // [R7]
        else $error("clocks running in suspend or snooze");
    a_refuse_lp: assert property (ce && lp_request && !clock_control[CLK_OSC_A_BIT]
        |=> mode == MODE_NORMAL && int_status[INT_REFUSED_BIT]) // [R5]
        else $error("low power entered without oscillator a");
    a_bias_mode: assert property (ce |=> regulator_low_bias == ($past(next_mode) == MODE_SNOOZE)) // [R9]
        else $error("regulator bias wrong for mode");
    a_stop_select: assert property (ce && pc0_wr && wr_data[PC0_STOP_BIT] && mode == MODE_NORMAL
        |=> mode == ($past(regulator_control[REG_STOP_SEL_BIT]) ? MODE_SHUTDOWN : MODE_STOP)) // [R12]
        else $error("stop select not honoured");
    a_shutdown_hold: assert property (ce && mode == MODE_SHUTDOWN && !pin_or_por
        |=> mode == MODE_SHUTDOWN && !ldo_on && pin_hold) // [R15]
        else $error("shutdown left without pin or power-on reset");
    a_stop_exit: assert property (ce && mode == MODE_STOP && any_reset
        |=> core_restart && mode == MODE_NORMAL ##1 !core_restart) // [R13]
        else $error("stop exit did not restart");
    a_lp_wake: assert property (ce && is_low_power(mode) && wake_lp |=> mode == MODE_NORMAL
        && int_status[INT_LP_WAKE_BIT]) // [R11]
        else $error("wake source did not end low power");
    a_irq_level: assert property (ce |=> irq == ($past(core_restart) ? 1'b0
        : |($past(int_status) & $past(int_mask))))
        else $error("interrupt output does not follow status");

    c_idle_wake: cover property (mode == MODE_IDLE ##1 mode == MODE_NORMAL);
    c_snooze_wake: cover property (mode == MODE_SNOOZE ##1 mode == MODE_NORMAL);
    c_shutdown_exit: cover property (mode == MODE_SHUTDOWN ##1 core_restart);
    c_refused: cover property (lp_refused);
endmodule : power_mode_controller

// file: testbench/power_mode_controller_tb_top.sv
// self-checking bench for the power mode controller
module power_mode_controller_tb_top
    import pmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // design inputs start settled, outputs are left to the design
    logic        aclk = 0, aresetn = 0, ce = 1;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, periph_clk_en;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        any_interrupt = 0, timer4_event = 0, spi_activity = 0, two_wire_slave_activity = 0;
    logic        port_match_event = 0, comparator0_out = 1, external_reset_pin_n = 1;
    logic        power_on_reset = 0, other_reset = 0, core_restart, irq, ldo_on, power_nets_on, pin_hold;
    logic        core_clk_en, fast_internal_osc_a_en, fast_internal_osc_b_en, slow_timer_clk_en;
    logic        regulator_low_bias, five_volt_reg_en;
    logic [2:0]  power_mode;
    // behavioural model state
    int          failures = 0, checks = 0, cycles = 0, seed = 10362;
    int          exp_mode = 0, exp_st = 0, exp_mask = 0, exp_reg = 0, exp_clk = 1, exp_pe = 255;

    power_mode_controller #(.NUM_PERIPH(8)) i_power_mode_controller (.*);

    always #5 aclk = ~aclk;

    // hang guard
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            failures++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    // axi4-lite write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, e);
    endtask : wr

    // axi4-lite read
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, er);
    endtask : rd

    // drive one wake or reset source by index, v = active
    task automatic src(input int k, input logic v);
        case (k)
            0: timer4_event <= v;
            1: spi_activity <= v;
            2: two_wire_slave_activity <= v;
            3: port_match_event <= v;
            4: comparator0_out <= !v;
            5: other_reset <= v;
            6: power_on_reset <= v;
            7: external_reset_pin_n <= !v;
            default: any_interrupt <= v;
        endcase
    endtask : src

    task automatic pulse(input int k);
        @(posedge aclk);
        src(k, 1'b1);
        repeat (6) @(posedge aclk);
        src(k, 0);
    endtask : pulse

    // restart from stop or shutdown returns the control registers to their reset values
    task automatic mreset();
        exp_mode = 0;
        exp_st = 0;
        exp_mask = 0;
        exp_reg = 0;
        exp_clk = 1;
        exp_pe = 255;
    endtask : mreset

    // compare every power output except core_restart with the model
    task automatic outs();
        repeat (2) @(posedge aclk);
        #1;
        chk(power_mode, exp_mode);
        chk(core_clk_en, exp_mode == 0);
        chk(periph_clk_en, exp_mode < 2 ? exp_pe : 0);
        chk(fast_internal_osc_a_en, exp_mode < 2);
        chk(fast_internal_osc_b_en, exp_clk[1] && exp_mode < 2);
        chk(slow_timer_clk_en, exp_clk[2] && exp_mode < 4);
        chk(regulator_low_bias, exp_mode == 3);
        chk(ldo_on, exp_mode != 5);
        chk({power_nets_on, pin_hold}, exp_mode < 4 ? 2'b10 : 2'b01);
        chk(five_volt_reg_en, exp_reg[1]);
        chk(irq, (exp_st & exp_mask) != 0);
    endtask : outs

    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        outs();
        rd(8'h20, 0, RESP_SLVERR);
        wr(8'h24, 1, RESP_SLVERR);
        exp_pe = $random(seed) & 255;
        wr(OFF_PERIPH, exp_pe);
        exp_mask = 7;
        wr(OFF_INT_MASK, exp_mask);
        // lane zero strobe low leaves the stop request without effect
        s_axi_wstrb <= 4'he;
        wr(OFF_PC0, 2);
        s_axi_wstrb <= 4'hf;
        wr(OFF_PC0, 1);
        exp_mode = 1;
        outs();
        rd(OFF_MODE, MODE_IDLE);
        // clock enable low freezes the idle state against an interrupt
        ce <= 1'b0;
        pulse(8);
        ce <= 1'b1;
        outs();
        pulse(8);
        exp_mode = 0;
        exp_st = 1;
        outs();
        exp_clk = 6;
        wr(OFF_CLKCTL, exp_clk);
        wr(OFF_PC1, 1);
        exp_st = 5;
        outs();
        exp_clk = 5;
        wr(OFF_CLKCTL, exp_clk);
        for (int k = 0; k < 5; k++)
        begin
            wr(OFF_PC1, k % 2 ? 3 : 1);           // snooze wins over suspend
            exp_mode = k % 2 ? 3 : 2;
            outs();
            pulse(k);
            exp_mode = 0;
            exp_st = 7;
            outs();
        end
        rd(OFF_INT_STATUS, 7);
        wr(OFF_INT_STATUS, 7);
        exp_st = 0;
        outs();
        for (int k = 5; k < 8; k++)
        begin
            exp_reg = 2;
            wr(OFF_REGCTL, exp_reg);
            wr(OFF_PC0, 2);
            exp_mode = 4;
            outs();
            pulse(k);
            mreset();
            outs();
        end
        exp_reg = 3;
        wr(OFF_REGCTL, exp_reg);
        wr(OFF_PC0, 2);
        exp_mode = 5;
        outs();
        pulse(5);
        outs();
        pulse(7);
        mreset();
        outs();
        summarize();
    end
endmodule : power_mode_controller_tb_top
